// ===== hw/vfdsd_pkg.sv
/*
 Shared constants of the display shift latch driver.
 Assumes a single 200 MHz system clock; the shift clock is sampled, not used as a clock.
*/
package vfdsd_pkg;
  // ****************************************************************
  // Sizes and timing
  // ****************************************************************
  localparam int STAGES        = 40;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SYNC_DEPTH    = 3;
  localparam int FIFO_DEPTH    = 16;
  localparam int FIFO_WIDTH    = 2;
  localparam int SHIFT_MAX_KHZ = 5000;
  localparam int SHIFT_MIN_CYC = (1000000000 / SHIFT_MAX_KHZ) / CLK_PERIOD_PS;
  // Field layout of one FIFO word: direction and data bit
  localparam int FLD_DATA = 0;
  localparam int FLD_DIR  = 1;
  localparam logic PIN_DEFAULT_HIGH = 1'h1;
  localparam logic PIN_DEFAULT_LOW  = 1'h0;
endpackage : vfdsd_pkg

// ===== hw/vfdsd_fifo_if.sv
/*
 Carrier between the shift engine and the FIFO module.
 Assumes both ends on the same clock.
*/
`timescale 1ns/1ps
interface vfdsd_fifo_if #(parameter int WIDTH = 2);
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;
  modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface : vfdsd_fifo_if

// ===== hw/vfdsd_fifo.sv
/*
 Small synchronous FIFO with valid and ready on both sides.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module vfdsd_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic   clk_in,
  input  wire logic   rst_n_in,
  // Streams
  vfdsd_fifo_if.fifo  port
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  wire              empty_w = (wr_ptr_reg == rd_ptr_reg);
  wire              full_w  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                              (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire              push_w  = port.wr_valid && !full_w;
  wire              pop_w   = port.rd_ready && !empty_w;
  assign port.wr_ready = !full_w;
  assign port.rd_valid = !empty_w;
  assign port.rd_data  = mem_reg[rd_ptr_reg[AW-1:0]];
  always_ff @(posedge clk_in) begin
    if (push_w) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= port.wr_data;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push_w) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop_w)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule : vfdsd_fifo

// ===== hw/vfdsd_driver.sv
/*
 Serial-in parallel-out display driver: shift register, strobe latch, output overrides.
 Assumes host pins arrive asynchronously; all are sampled on clk_in.
*/
// Notes on behaviour
// - Forty stages advance one position per shift clock rising edge.
// - A one on serial input turns the matching driver output on.
// - Direction high: data moves toward stage 40, new bit enters stage 1.
// - Direction low: data moves toward stage 1, new bit enters stage 40.
// - Direction high: cascade output shows stage 40.
// - Direction low: cascade output shows stage 1.
// - Strobe high: latch is transparent to the shift stages.
// - Strobe falling: latch holds the stages until strobe rises again.
// - Blanking low forces every driver output low.
// - Blanking high, test low: outputs follow the latch.
// - Blanking high, test high: all outputs forced high.
// - Blanking input reads high when undriven.
// - Test input reads low when undriven.
// - Direction input reads high when undriven.
// - Without a shift clock rise, stages and cascade output stay unchanged.
// - Stages are not initialised and may hold anything until loaded.
`timescale 1ns/1ps
module vfdsd_driver #(
  parameter int STAGES = vfdsd_pkg::STAGES
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // Serial link from host
  input  wire logic              shift_clk_in,
  input  wire logic              serial_data_in,
  input  wire logic              shift_dir_in,
  input  wire logic              shift_dir_oe_in,
  // Latch and override controls
  input  wire logic              latch_strobe_in,
  input  wire logic              blank_n_in,
  input  wire logic              blank_n_oe_in,
  input  wire logic              all_on_test_in,
  input  wire logic              all_on_test_oe_in,
  // Outputs
  output logic                   cascade_out,
  output logic [STAGES-1:0]      drive_out,
  output logic                   fifo_stall_out
);
  initial begin
    if (STAGES < 2) $error("STAGES must be at least two");
  end

  // ****************************************************************
  // Pin resolution and synchronisers
  // ****************************************************************
  // Undriven pins resolve through their pulls before sampling
  wire dir_pin_w   = shift_dir_oe_in   ? shift_dir_in   : vfdsd_pkg::PIN_DEFAULT_HIGH;
  wire blank_pin_w = blank_n_oe_in     ? blank_n_in     : vfdsd_pkg::PIN_DEFAULT_HIGH;
  wire test_pin_w  = all_on_test_oe_in ? all_on_test_in : vfdsd_pkg::PIN_DEFAULT_LOW;

  localparam int NPIN = 6;
  wire  [NPIN-1:0] pins_w = {test_pin_w, blank_pin_w, latch_strobe_in,
                             dir_pin_w, serial_data_in, shift_clk_in};
  logic [NPIN-1:0] s1_reg;
  logic [NPIN-1:0] s2_reg;
  logic [NPIN-1:0] s3_reg;
  logic [NPIN-1:0] clean_reg;
  // A change counts once the second and third stages agree
  wire  [NPIN-1:0] agree_w    = ~(s2_reg ^ s3_reg);
  wire  [NPIN-1:0] clean_next = (agree_w & s2_reg) | (~agree_w & clean_reg);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      clean_reg <= '0;
    end else begin
      s1_reg    <= pins_w;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      clean_reg <= clean_next;
    end
  end

  wire sclk_w   = clean_reg[0];
  wire sdata_w  = clean_reg[1];
  wire sdir_w   = clean_reg[2];
  wire strobe_w = clean_reg[3];
  wire blank_w  = clean_reg[4];
  wire test_w   = clean_reg[5];

  // ****************************************************************
  // Shift clock edge detection
  // ****************************************************************
  logic sclk_prev_reg;
  // Data is taken as sampled at the rise, so it was set up while low
  wire  rise_w = sclk_w && !sclk_prev_reg;
  // Pins sample together, so data and direction pair with this edge
  wire [vfdsd_pkg::FIFO_WIDTH-1:0] word_w;
  assign word_w[vfdsd_pkg::FLD_DATA] = sdata_w;
  assign word_w[vfdsd_pkg::FLD_DIR]  = sdir_w;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_prev_reg <= 1'h0;
    end else begin
      sclk_prev_reg <= sclk_w;
    end
  end

  // ****************************************************************
  // Edge FIFO
  // ****************************************************************
  // Absorbs edges while the shifter waits; at the legal rate it never fills
  vfdsd_fifo_if #(.WIDTH(vfdsd_pkg::FIFO_WIDTH)) fq ();
  assign fq.wr_valid = rise_w;
  assign fq.wr_data  = word_w;

  vfdsd_fifo #(
    .WIDTH (vfdsd_pkg::FIFO_WIDTH),
    .DEPTH (vfdsd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .port     (fq.fifo)
  );

  // ****************************************************************
  // Shift register
  // ****************************************************************
  logic [STAGES-1:0] stage_reg;
  logic              strobe_prev_reg;
  logic              hold_pend_reg;
  // Shifting stalls for one cycle at a strobe fall so the latch captures first
  wire               strobe_fall_w = strobe_prev_reg && !strobe_w;
  wire               take_w        = fq.rd_valid && !strobe_fall_w;
  assign fq.rd_ready = take_w;
  wire               in_bit_w = fq.rd_data[vfdsd_pkg::FLD_DATA];
  wire               in_dir_w = fq.rd_data[vfdsd_pkg::FLD_DIR];
  // Index 0 is stage 1
  wire [STAGES-1:0]  up_w   = {stage_reg[STAGES-2:0], in_bit_w};
  wire [STAGES-1:0]  down_w = {in_bit_w, stage_reg[STAGES-1:1]};
  wire [STAGES-1:0]  stage_next = take_w ? (in_dir_w ? up_w : down_w) : stage_reg;
  // Cascade tap follows the direction the edge used
  wire               casc_next  = take_w ? (in_dir_w ? up_w[STAGES-1] : down_w[0])
                                         : cascade_out;

  // No reset: stages power up undefined and need loading
  always_ff @(posedge clk_in) begin
    stage_reg <= stage_next;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cascade_out     <= 1'h0;
      strobe_prev_reg <= 1'h0;
      fifo_stall_out  <= 1'h0;
    end else begin
      cascade_out     <= casc_next;
      strobe_prev_reg <= strobe_w;
      fifo_stall_out  <= !fq.wr_ready;
    end
  end

  // ****************************************************************
  // Latch and output stage
  // ****************************************************************
  logic [STAGES-1:0] latch_q_reg;
  wire  [STAGES-1:0] latch_q_next = strobe_w ? stage_reg : latch_q_reg;
  // Registered so outputs come straight from flip-flops; one cycle of lag
  wire  [STAGES-1:0] drive_next   = !blank_w ? '0 :
                                    test_w   ? '1 :
                                    latch_q_next;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_q_reg <= '0;
      drive_out   <= '0;
    end else begin
      latch_q_reg <= latch_q_next;
      drive_out   <= drive_next;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_BLANK_LOW: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !blank_w |=> drive_out == '0) else $error("blanking did not force outputs low");
  AST_TEST_HIGH: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    blank_w && test_w |=> drive_out == '1) else $error("test did not force outputs high");
  // Case equality: stages are unreset, so unloaded bits must compare as they are
  AST_FOLLOW: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    blank_w && !test_w |=> drive_out === $past(latch_q_next))
    else $error("outputs do not follow latch");
  AST_TRANSP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    strobe_w |=> latch_q_reg === $past(stage_reg)) else $error("latch not transparent");
  AST_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !strobe_w |=> $stable(latch_q_reg)) else $error("latch changed while held");
  AST_UP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_w && in_dir_w |=> stage_reg[0] === $past(in_bit_w) &&
    stage_reg[STAGES-1:1] === $past(stage_reg[STAGES-2:0])) else $error("up shift wrong");
  AST_DOWN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_w && !in_dir_w |=> stage_reg[STAGES-1] === $past(in_bit_w) &&
    stage_reg[STAGES-2:0] === $past(stage_reg[STAGES-1:1])) else $error("down shift wrong");
  AST_STILL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !take_w |=> $stable(stage_reg) && $stable(cascade_out)) else $error("shifted without edge");
  AST_CASC: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_w && in_dir_w |=> cascade_out === stage_reg[STAGES-1]) else $error("cascade tap wrong");
  AST_CASC_LO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_w && !in_dir_w |=> cascade_out === stage_reg[0]) else $error("cascade tap wrong");
  AST_FALL_FIRST: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    strobe_fall_w |-> !take_w) else $error("shift taken at strobe fall");
  AST_STALL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |=> fifo_stall_out == $past(!fq.wr_ready)) else $error("stall flag wrong");
  AST_EDGE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rise_w |-> ##[0:16] take_w) else $error("edge not applied");

  COV_UP:    cover property (@(posedge clk_in) disable iff (!rst_n_in) take_w && in_dir_w);
  COV_DOWN:  cover property (@(posedge clk_in) disable iff (!rst_n_in) take_w && !in_dir_w);
  COV_FALL:  cover property (@(posedge clk_in) disable iff (!rst_n_in) strobe_fall_w);
  COV_TEST:  cover property (@(posedge clk_in) disable iff (!rst_n_in) blank_w && test_w);
endmodule : vfdsd_driver

// ===== tb/vfdsd_host_model.sv
/*
 Host model that drives the serial link of the display driver.
 Assumes the driver samples the link on its own unrelated clock.
*/
`timescale 1ns/1ps
module vfdsd_host_model (
  // Serial link
  output logic shift_clk_out,
  output logic serial_data_out
);
  // ****************************************************************
  // Bit transfer, 125 ns per bit
  // ****************************************************************
  initial begin
    shift_clk_out   = 1'h0; // Clock stands low between frames
    serial_data_out = 1'h0;
  end
  task automatic send_one(input logic bit_val);
    #31.25 serial_data_out = bit_val;
    #31.25 shift_clk_out   = 1'h1;
    #62.5  shift_clk_out   = 1'h0;
  endtask : send_one
  task automatic send_word(input logic [39:0] word);
    for (int i = 39; i >= 0; i--) begin
      send_one(word[i]);
    end
    #31.25 serial_data_out = ~serial_data_out; // Released line shows no stale value
  endtask : send_word
  task automatic send_bit(input logic bit_val);
    send_one(bit_val);
    #31.25 serial_data_out = ~serial_data_out;
  endtask : send_bit
endmodule : vfdsd_host_model

// ===== tb/vfdsd_driver_tb.sv
/*
 Self-checking bench of the display driver and its FIFO.
 Assumes the host model owns the shift clock and the serial data line.
*/
`timescale 1ns/1ps
module vfdsd_driver_tb;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  localparam logic [39:0] PAT = 40'hA5C30F96E1;
  logic        clk_in = 1'h0;
  logic        rst_n_in = 1'h0;
  logic        shift_clk, serial_data, cascade_out, fifo_stall_out;
  logic        dir = 1'h1, dir_oe = 1'h1, strobe = 1'h1;
  logic        bl_n = 1'h0, bl_oe = 1'h1, tst = 1'h0, tst_oe = 1'h1;
  logic [39:0] drive_out, exp_v;
  logic [5:0]  rows [7] = '{6'h14, 6'h1C, 6'h3D, 6'h0D, 6'h02, 6'h3A, 6'h36};
  int          error_cnt = 0;
  int          n_compared = 0;
  always #2.5 clk_in = ~clk_in;
  vfdsd_host_model u_vfdsd_host_model (.shift_clk_out(shift_clk), .serial_data_out(serial_data));
  vfdsd_driver u_vfdsd_driver (.clk_in(clk_in), .rst_n_in(rst_n_in), .shift_clk_in(shift_clk),
    .serial_data_in(serial_data), .shift_dir_in(dir), .shift_dir_oe_in(dir_oe),
    .latch_strobe_in(strobe), .blank_n_in(bl_n), .blank_n_oe_in(bl_oe),
    .all_on_test_in(tst), .all_on_test_oe_in(tst_oe), .cascade_out(cascade_out),
    .drive_out(drive_out), .fifo_stall_out(fifo_stall_out));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic settle();
    repeat (20) @(posedge clk_in);
  endtask : settle
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (4) @(posedge clk_in);
    check("reset drive", drive_out, 40'h0);
    check("reset cascade", {39'h0, cascade_out}, 40'h0);
    check("reset stall", {39'h0, fifo_stall_out}, 40'h0);
    rst_n_in <= 1'h1;
    repeat (2) @(posedge clk_in);
    u_vfdsd_host_model.send_word(PAT);
    settle();
    check("blanked drive", drive_out, 40'h0);
    // Row: blank, blank_oe, test, test_oe, expect select (0 low, 1 high, 2 pattern)
    foreach (rows[i]) begin
      @(posedge clk_in);
      {bl_n, bl_oe, tst, tst_oe} <= rows[i][5:2];
      settle();
      exp_v = rows[i][1] ? PAT : (rows[i][0] ? '1 : '0);
      check("override drive", drive_out, exp_v);
    end
    check("cascade dir high", {39'h0, cascade_out}, {39'h0, PAT[39]});
    dir <= 1'h0;
    u_vfdsd_host_model.send_bit(1'h1);
    settle();
    exp_v = {1'h1, PAT[39:1]};
    check("drive dir low", drive_out, exp_v);
    check("cascade dir low", {39'h0, cascade_out}, {39'h0, exp_v[0]});
    dir_oe <= 1'h0;
    u_vfdsd_host_model.send_bit(1'h0);
    settle();
    exp_v = {exp_v[38:0], 1'h0};
    check("drive dir pulled", drive_out, exp_v);
    check("cascade dir pulled", {39'h0, cascade_out}, {39'h0, exp_v[39]});
    strobe <= 1'h0;
    settle();
    repeat (3) u_vfdsd_host_model.send_bit(1'h1);
    settle();
    check("held drive", drive_out, exp_v);
    check("cascade while held", {39'h0, cascade_out}, {39'h0, exp_v[36]});
    strobe <= 1'h1;
    settle();
    check("released drive", drive_out, {exp_v[36:0], 3'h7});
    check("stall", {39'h0, fifo_stall_out}, 40'h0);
    // Full reload at 125 ns per bit, faster than the legal rate, through the edge queue
    u_vfdsd_host_model.send_word(~PAT);
    settle();
    check("reload drive", drive_out, ~PAT);
    check("reload cascade", {39'h0, cascade_out}, {39'h0, ~PAT[39]});
    check("reload stall", {39'h0, fifo_stall_out}, 40'h0);
    stop_test();
  end
endmodule : vfdsd_driver_tb
